// [design/ubre_bus_reset_exit.sv]
// Purpose: Detects USB bus reset and decides exit to connected state.
// Assumes: dp/dm are raw pins; override is on-chip and synchronous.
// Notes: Counts above 4096 cycles are parameters for short simulations.
`timescale 1ns/100ps
`default_nettype none
module ubre_bus_reset_exit
   import ubre_pkg::*;
#(
   parameter int RESET_CYC = UBRE_RESET_CYC,
   parameter int IDLE_CYC = UBRE_IDLE_CYC,
   parameter bit FIXED_REV = 1'b0
)
(
   input wire logic core_clk,
   input wire logic srst,
   input wire logic dp_in,
   input wire logic dm_in,
   input wire logic force_j_en,
   input wire logic debug_override_pin,
   input wire logic pkt_valid,
   output logic in_reset,
   output logic connected,
   output logic pkt_accept
);
   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic [1:0] dp_sync_reg;
   logic [1:0] dm_sync_reg;
   logic [1:0] dp_sync_next;
   logic [1:0] dm_sync_next;
   logic dp_view;
   logic dm_view;
   logic se0;
   logic jst;
   ubre_state_type state_reg;
   ubre_state_type state_next;
   logic [UBRE_CNT_W-1:0] se0_cnt_reg;
   logic [UBRE_CNT_W-1:0] se0_cnt_next;
   logic [UBRE_CNT_W-1:0] idle_cnt_reg;
   logic [UBRE_CNT_W-1:0] idle_cnt_next;
   logic accept_reg;
   logic accept_next;

   // Shift raw pins; first stage feeds only the second
   always_comb
   begin
      dp_sync_next = {dp_sync_reg[0], dp_in};
      dm_sync_next = {dm_sync_reg[0], dm_in};
   end

   always_ff @(posedge core_clk)
   begin
      // Reset to the idle J view so no false SE0 follows reset
      if (srst)
      begin
         dp_sync_reg <= 2'h3;
         dm_sync_reg <= 2'h0;
      end
      else
      begin
         dp_sync_reg <= dp_sync_next;
         dm_sync_reg <= dm_sync_next;
      end
   end

   // ----------------------------------------
   // Line view with debug override
   // ----------------------------------------
   // forced J view
   // pin level ignored, only the internal enable steers the view
   assign dp_view = force_j_en ? 1'b1 : dp_sync_reg[1];
   assign dm_view = force_j_en ? 1'b0 : dm_sync_reg[1];
   assign se0 = !dp_view && !dm_view;
   assign jst = dp_view && !dm_view;

   // ----------------------------------------
   // Reset and exit state machine
   // ----------------------------------------
   // ----------------------------------------
   // SE0 run length
   // ----------------------------------------
   logic se0_full;
   logic se0_long;

   // Counter saturates so a very long SE0 never wraps back to zero
   assign se0_full = se0_cnt_reg >= UBRE_CNT_W'(RESET_CYC);
   assign se0_long = se0 && se0_cnt_reg == UBRE_CNT_W'(RESET_CYC - 1);

   // Any cycle without SE0 clears the run
   always_comb
   begin
      se0_cnt_next = '0;
      if (se0)
      begin
         se0_cnt_next = se0_cnt_reg;
         if (!se0_full)
         begin
            se0_cnt_next = UBRE_CNT_W'(se0_cnt_reg + 1'b1);
         end
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         se0_cnt_reg <= '0;
      end
      else
      begin
         se0_cnt_reg <= se0_cnt_next;
      end
   end

   // ----------------------------------------
   // Idle J run length
   // ----------------------------------------
   logic idle_done;

   // Last cycle of the required unbroken idle interval
   assign idle_done = idle_cnt_reg == UBRE_CNT_W'(IDLE_CYC - 1);

   // Counts only while waiting in reset; the fixed revision never uses it
   always_comb
   begin
      idle_cnt_next = '0;
      if (!FIXED_REV && state_reg == UBRE_ST_RESET && jst && !idle_done)
      begin
         idle_cnt_next = UBRE_CNT_W'(idle_cnt_reg + 1'b1);
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         idle_cnt_reg <= '0;
      end
      else
      begin
         idle_cnt_reg <= idle_cnt_next;
      end
   end

   // ----------------------------------------
   // Reset and exit state machine
   // ----------------------------------------
   // Bus traffic to other devices shows K/SE0 and holds the device in reset;
   // that is the known weakness of the older revision, kept on purpose
   always_comb
   begin
      state_next = state_reg;
      unique case (state_reg)
         UBRE_ST_CONNECTED:
         begin
            if (se0_long)
            begin
               state_next = UBRE_ST_RESET;
            end
         end
         UBRE_ST_RESET:
         begin
            if (FIXED_REV)
            begin
               if (!se0)
               begin
                  state_next = UBRE_ST_CONNECTED;
               end
            end
            else if (jst && idle_done)
            begin
               state_next = UBRE_ST_CONNECTED;
            end
         end
         default:
         begin
            // Illegal code falls back to the safe reset state
            state_next = UBRE_ST_RESET;
         end
      endcase
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         state_reg <= UBRE_ST_RESET;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   // ----------------------------------------
   // Packet gate
   // ----------------------------------------
   // accept only when connected
   // Uses the present state, so a packet in the exit cycle is still refused
   always_comb
   begin
      accept_next = pkt_valid && state_reg == UBRE_ST_CONNECTED;
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         accept_reg <= 1'b0;
      end
      else
      begin
         accept_reg <= accept_next;
      end
   end

   assign pkt_accept = accept_reg;

   // ----------------------------------------
   // Status outputs
   // ----------------------------------------
   logic in_reset_next;
   logic connected_next;

   // Decoded from the next state so the flags track the state register
   always_comb
   begin
      in_reset_next = state_next == UBRE_ST_RESET;
      connected_next = state_next == UBRE_ST_CONNECTED;
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         in_reset <= 1'b1;
         connected <= 1'b0;
      end
      else
      begin
         in_reset <= in_reset_next;
         connected <= connected_next;
      end
   end

   // ----------------------------------------
   // Unused pin
   // ----------------------------------------
   // pin level ignored
   // Kept as a port so the override path matches the pin map
   logic unused_pin;
   assign unused_pin = debug_override_pin;
endmodule
`default_nettype wire

// [design/ubre_pkg.sv]
// Purpose: Constants for the bus reset exit block.
// Assumes: core_clk at 25 MHz.
// Notes: Line states use the full-speed J/K/SE0 coding.
package ubre_pkg;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int UBRE_CLK_KHZ = 25000;
   localparam int UBRE_RESET_SE0_US = 10000;
   localparam int UBRE_IDLE_US = 800;
   localparam int UBRE_RESET_CYC = UBRE_RESET_SE0_US * (UBRE_CLK_KHZ / 1000);
   localparam int UBRE_IDLE_CYC = UBRE_IDLE_US * (UBRE_CLK_KHZ / 1000);
   localparam int UBRE_CNT_W = 18;
   // ----------------------------------------
   // Link states
   // ----------------------------------------
   typedef enum logic [1:0]
   {
      UBRE_ST_CONNECTED = 2'b00,
      UBRE_ST_RESET = 2'b01
   } ubre_state_type;
endpackage

// [tb/tb_top.sv]
// Purpose: Bench for reset exit.
// Assumes: Counts cut to 20 and 10.
// Notes: i_fix is the fixed revision.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic core_clk = 1'b0, srst = 1'b1, dp_in, dm_in, in_reset, connected, pkt_accept;
   logic force_j_en = 1'b0, debug_override_pin = 1'b0, pkt_valid = 1'b0;
   logic [1:0] mode = 2'h0;
   logic fix_in_reset, fix_connected, fix_pkt_accept;
   int err_total = 0, n_compared = 0;
   initial forever #20 core_clk = ~core_clk;
   ubre_host i_host (.core_clk(core_clk), .mode(mode), .dp(dp_in), .dm(dm_in));
   ubre_bus_reset_exit #(.RESET_CYC(20), .IDLE_CYC(10), .FIXED_REV(1'b0)) i_dut (
      .core_clk(core_clk), .srst(srst), .dp_in(dp_in), .dm_in(dm_in),
      .force_j_en(force_j_en), .debug_override_pin(debug_override_pin),
      .pkt_valid(pkt_valid), .in_reset(in_reset), .connected(connected),
      .pkt_accept(pkt_accept));
   ubre_bus_reset_exit #(.RESET_CYC(20), .IDLE_CYC(10), .FIXED_REV(1'b1)) i_fix (
      .core_clk(core_clk), .srst(srst), .dp_in(dp_in), .dm_in(dm_in),
      .force_j_en(force_j_en), .debug_override_pin(debug_override_pin),
      .pkt_valid(pkt_valid), .in_reset(fix_in_reset), .connected(fix_connected),
      .pkt_accept(fix_pkt_accept));
   task chk(input logic a, input logic e);
      n_compared++;
      if (a !== e)
      begin
         err_total++;
         $display("BAD %0t %h %h", $time, a, e);
      end
   endtask
   task t_busy;
      mode = 2'h2;
      debug_override_pin = 1'b1;
      repeat (40) @(negedge core_clk);
      chk(in_reset, 1'b1);
      chk(fix_connected, 1'b1);
      pkt_valid = 1'b1;
      @(negedge core_clk);
      chk(pkt_accept, 1'b0);
      chk(fix_pkt_accept, 1'b1);
      pkt_valid = 1'b0;
      $display("busy done");
   endtask
   task t_force;
      force_j_en = 1'b1;
      repeat (14) @(negedge core_clk);
      chk(connected, 1'b1);
      force_j_en = 1'b0;
      mode = 2'h0;
      pkt_valid = 1'b1;
      @(negedge core_clk);
      chk(pkt_accept, 1'b1);
      pkt_valid = 1'b0;
      $display("force done");
   endtask
   task t_reset;
      mode = 2'h1;
      repeat (30) @(negedge core_clk);
      chk(in_reset, 1'b1);
      chk(fix_in_reset, 1'b1);
      mode = 2'h0;
      repeat (20) @(negedge core_clk);
      chk(connected, 1'b1);
      chk(fix_connected, 1'b1);
      $display("reset done");
   endtask
   task end_sim;
      $display("compared %0d bad %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial
   begin
      repeat (6) @(negedge core_clk);
      srst = 1'b0;
      t_busy;
      t_force;
      t_reset;
      end_sim;
   end
endmodule
`default_nettype wire

// [tb/ubre_chk_props.sv]
// Purpose: Port checks for reset exit.
// Assumes: Bound to every instance.
// Notes: Windows allow the sync delay.
`timescale 1ns/100ps
`default_nettype none
module ubre_chk #(parameter int RESET_CYC = 20, parameter bit FIXED_REV = 1'b0)
(
   input wire logic core_clk,
   input wire logic srst,
   input wire logic dp_in,
   input wire logic dm_in,
   input wire logic force_j_en,
   input wire logic debug_override_pin,
   input wire logic pkt_valid,
   input wire logic in_reset,
   input wire logic connected,
   input wire logic pkt_accept
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);
   int se0_reg;
   // Raw SE0 run length
   always_ff @(posedge core_clk) se0_reg <= (srst | dp_in | dm_in | force_j_en) ? 0 : se0_reg + 1;
   wire logic kx = !FIXED_REV && in_reset && !force_j_en;
   chk_reset_entry: assert property (se0_reg == RESET_CYC + 5 |-> in_reset)
      else $error("late reset");
   chk_idle_exit: assert property ((dp_in && !dm_in) [*8] ##1 (dp_in && !dm_in) [*8] |=> connected)
      else $error("no exit");
   chk_pkt_gate: assert property (pkt_accept |-> $past(pkt_valid) && $past(connected))
      else $error("bad accept");
   chk_pkt_pass: assert property (connected && pkt_valid |=> pkt_accept)
      else $error("lost packet");
   chk_busy_hold: assert property (kx && !dp_in |-> ##3 !$rose(connected) [*6])
      else $error("early exit");
   chk_force_exit: assert property (force_j_en [*8] ##1 force_j_en [*4] |=> connected)
      else $error("no forced exit");
   chk_pin_ignored: assert property (kx && debug_override_pin && dm_in |-> ##3 !$rose(connected) [*4])
      else $error("pin exit");
   chk_fixed_exit: assert property (FIXED_REV && in_reset && dp_in && !dm_in ##1 dp_in && !dm_in |-> ##[1:3] connected)
      else $error("fixed no exit");
endmodule
bind ubre_bus_reset_exit ubre_chk #(.RESET_CYC(RESET_CYC), .FIXED_REV(FIXED_REV)) i_chk (
   .core_clk(core_clk),
   .srst(srst),
   .dp_in(dp_in),
   .dm_in(dm_in),
   .force_j_en(force_j_en),
   .debug_override_pin(debug_override_pin),
   .pkt_valid(pkt_valid),
   .in_reset(in_reset),
   .connected(connected),
   .pkt_accept(pkt_accept)
);
`default_nettype wire

// [tb/ubre_host.sv]
// Purpose: Host line model.
// Assumes: mode 0 idle J, 1 SE0, 2 busy.
// Notes: Busy puts one K in eight cycles.
`timescale 1ns/100ps
`default_nettype none
module ubre_host (
   input wire logic core_clk,
   input wire logic [1:0] mode,
   output logic dp,
   output logic dm
);
   logic [2:0] ph_reg = 3'h0;
   // Polling phase, free running
   always_ff @(posedge core_clk) ph_reg <= ph_reg + 3'h1;
   assign {dp, dm} = (mode == 2'h1) ? 2'h0 : (mode == 2'h2 && ph_reg == 3'h0) ? 2'h1 : 2'h2;
endmodule
`default_nettype wire
